// *** hw/transmit_descriptor_pointer_pkg.sv ***
// Package for the transmit descriptor pointer block.
// Assumes a single 50 MHz core clock and a plain register port.
package transmit_descriptor_pointer_pkg;
    localparam logic [7:0]  TRANSMIT_DESCRIPTOR_POINTER_OFFSET   = 8'h20;
    localparam logic [7:0]  CMD_OFFSET    = 8'h04;
    localparam logic [7:0]  STATUS_OFFSET = 8'h08;
    localparam int          TX_ENABLE_POS = 0;
    localparam int          LINK_OFFSET   = 0;
    localparam logic [31:0] TRANSMIT_DESCRIPTOR_POINTER_RESET    = 32'h0000_0000;
    localparam logic [31:0] NULL_LINK     = 32'h0000_0000;
    localparam logic [1:0]  ALIGN_MASK    = 2'h0;

    // Register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    // Descriptor memory fetch request and answer
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } fetch_req_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] link;
    } fetch_rsp_t;
endpackage

// *** hw/tx_descriptor_list_pointer.sv ***
// Transmit descriptor list pointer with link-field fetch sequencer.
// Assumes a same-clock memory port that answers each fetch with one
// valid pulse, and a transmit engine that pulses desc_done per descriptor.
// Enable writes that arrive while the sequencer is busy are dropped; the
// walk already re-reads the current link each time a descriptor completes,
// so an appended descriptor is still found.
//
// Notes on behaviour
// - The pointer register is 32 bits wide, bits 31..2 hold the address, bits 1..0 unused.
// - While active, the pointer follows each descriptor along the linked list.
// - A null link field leaves the pointer on the current descriptor.
// - A write of the transmit enable bit while the sequencer is idle re-reads the current link field.
// - Hard and soft reset clear the pointer to zero.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
module tx_descriptor_list_pointer (
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic                 soft_rst,
    input  wire transmit_descriptor_pointer_pkg::reg_req_t   req,
    output      logic [31:0]          rdata,
    input  wire logic                 desc_done,
    output      transmit_descriptor_pointer_pkg::fetch_req_t fetch,
    input  wire transmit_descriptor_pointer_pkg::fetch_rsp_t fetch_rsp,
    output      logic                 tx_active,
    output      logic [31:0]          cur_desc
);
    import transmit_descriptor_pointer_pkg::*;

    typedef enum {ST_IDLE, ST_FETCH, ST_WAIT, ST_ACTIVE} tx_state_t;

    tx_state_t   state_q, state_d;
    logic [29:0] ptr_q, ptr_d;
    logic [31:0] rdata_q, rdata_d;
    logic        fetch_q, fetch_d;
    logic        at_end_q, at_end_d;
    logic        active_q, active_d;
    logic [31:0] fetch_addr_q, fetch_addr_d;
    logic        te_write;
    logic        ptr_write;

    // Strobe decodes; a command write with the enable bit clear is no command
    assign te_write  = req.wr && req.addr == CMD_OFFSET && req.wdata[TX_ENABLE_POS];
    assign ptr_write = req.wr && req.addr == TRANSMIT_DESCRIPTOR_POINTER_OFFSET;

    // Next-state logic for sequencer, pointer and read data
    always_comb begin
        state_d  = state_q;
        ptr_d    = ptr_q;
        fetch_d  = 1'b0;
        at_end_d = at_end_q;
        rdata_d  = 32'h0000_0000;
        unique case (state_q)
            ST_IDLE: begin
                if (ptr_write) begin
                    ptr_d = req.wdata[31:2];
                end
                if (te_write) begin
                    state_d = ST_FETCH;
                end
            end
            ST_FETCH: begin
                // Single-cycle request; the address flop is already loaded
                fetch_d = 1'b1;
                state_d = ST_WAIT;
            end
            ST_WAIT: begin
                // Answers outside this state are ignored
                if (fetch_rsp.valid) begin
                    if (fetch_rsp.link == NULL_LINK) begin
                        at_end_d = 1'b1;
                        state_d  = ST_IDLE;
                    end else begin
                        ptr_d    = fetch_rsp.link[31:2];
                        at_end_d = 1'b0;
                        state_d  = ST_ACTIVE;
                    end
                end
            end
            ST_ACTIVE: begin
                if (desc_done) begin
                    state_d = ST_FETCH;
                end
            end
        endcase
        if (req.rd) begin
            if (req.addr == TRANSMIT_DESCRIPTOR_POINTER_OFFSET) begin
                rdata_d = {ptr_q, ALIGN_MASK};
            end else if (req.addr == STATUS_OFFSET) begin
                rdata_d = {30'h0, at_end_q, state_q != ST_IDLE};
            end
        end
        // Next values of the output flops; busy follows the next state
        active_d     = state_d != ST_IDLE;
        fetch_addr_d = {ptr_d, ALIGN_MASK} + 32'(LINK_OFFSET);
    end

    // Registers; both resets clear the pointer
    always_ff @(posedge core_clk) begin
        if (rst || soft_rst) begin
            state_q  <= ST_IDLE;
            ptr_q    <= TRANSMIT_DESCRIPTOR_POINTER_RESET[31:2];
            fetch_q  <= 1'b0;
            at_end_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
        end else begin
            state_q  <= state_d;
            ptr_q    <= ptr_d;
            fetch_q  <= fetch_d;
            at_end_q <= at_end_d;
            rdata_q  <= rdata_d;
        end
    end

    // Output flops; the fetch address loads every cycle so that it is
    // already settled when the fetch pulse leaves the sequencer
    always_ff @(posedge core_clk) begin
        if (rst || soft_rst) begin
            active_q     <= 1'b0;
            fetch_addr_q <= 32'h0000_0000;
        end else begin
            active_q     <= active_d;
            fetch_addr_q <= fetch_addr_d;
        end
    end

    // Outputs from flops; the low pointer bits are fixed at zero
    assign rdata       = rdata_q;
    assign fetch.valid = fetch_q;
    assign fetch.addr  = fetch_addr_q;
    assign tx_active   = active_q;
    assign cur_desc    = {ptr_q, ALIGN_MASK};

    // Link fetch steps
    sequence s_enable_write;
        state_q == ST_IDLE && te_write;
    endsequence
    sequence s_fetch_issued;
        ##2 fetch.valid && fetch.addr == $past(cur_desc, 2);
    endsequence
    // A finished descriptor seen while walking
    sequence s_done_seen;
        state_q == ST_ACTIVE && desc_done;
    endsequence

    chk_pointer_reset: assert property (@(posedge core_clk)
        (rst || soft_rst) |=> cur_desc == 32'h0000_0000)
        else $error("pointer not cleared by reset");
    chk_low_bits: assert property (@(posedge core_clk) disable iff (rst)
        cur_desc[1:0] == 2'h0 && (!$past(req.rd) || $past(req.addr) != TRANSMIT_DESCRIPTOR_POINTER_OFFSET
        || rdata[1:0] == 2'h0))
        else $error("pointer low bits not zero");
    chk_idle_load: assert property (@(posedge core_clk) disable iff (rst || soft_rst)
        (state_q == ST_IDLE && ptr_write) |=> cur_desc[31:2] == $past(req.wdata[31:2]))
        else $error("idle pointer load lost");
    chk_refetch: assert property (@(posedge core_clk) disable iff (rst || soft_rst)
        s_enable_write |-> s_fetch_issued)
        else $error("enable write did not re-read link");
    chk_null_hold: assert property (@(posedge core_clk) disable iff (rst || soft_rst)
        (state_q == ST_WAIT && fetch_rsp.valid && fetch_rsp.link == 32'h0)
        |=> $stable(cur_desc) && !tx_active)
        else $error("pointer moved on null link");
    chk_link_move: assert property (@(posedge core_clk) disable iff (rst || soft_rst)
        (state_q == ST_WAIT && fetch_rsp.valid && fetch_rsp.link != 32'h0)
        |=> cur_desc[31:2] == $past(fetch_rsp.link[31:2]) && tx_active)
        else $error("pointer did not follow link");
    // The list-walk check reuses the fetch sequence above
    // Walk keeps fetching
    chk_follow_list: assert property (@(posedge core_clk)
        disable iff (rst || soft_rst)
        s_done_seen |-> s_fetch_issued)
        else $error("active list walk stalled");
    chk_active_hold: assert property (@(posedge core_clk)
        disable iff (rst || soft_rst)
        (state_q != ST_IDLE && !(state_q == ST_WAIT && fetch_rsp.valid)) |=> $stable(cur_desc))
        else $error("pointer changed while busy");

    // Software loads that arrive mid-walk must not disturb the list position
    // Busy loads ignored
    chk_busy_load: assert property (@(posedge core_clk)
        disable iff (rst || soft_rst)
        (ptr_write && (state_q == ST_FETCH || state_q == ST_ACTIVE)) |=> $stable(cur_desc))
        else $error("pointer load taken while busy");
    chk_pointer_read: assert property (@(posedge core_clk)
        disable iff (rst || soft_rst)
        (req.rd && req.addr == TRANSMIT_DESCRIPTOR_POINTER_OFFSET) |=> rdata == $past(cur_desc))
        else $error("pointer read returned wrong value");
    chk_rdata_quiet: assert property (@(posedge core_clk)
        disable iff (rst || soft_rst)
        !req.rd |=> rdata == 32'h0000_0000)
        else $error("read data present without a read");
    chk_busy_status: assert property (@(posedge core_clk)
        disable iff (rst || soft_rst)
        (req.rd && req.addr == STATUS_OFFSET) |=> rdata[0] == $past(tx_active))
        else $error("status busy bit wrong");

    // The memory port sees exactly one request per link read
    // Single fetch pulse
    chk_fetch_pulse: assert property (@(posedge core_clk)
        disable iff (rst || soft_rst)
        fetch.valid |=> !fetch.valid)
        else $error("fetch request longer than one cycle");
    chk_fetch_source: assert property (@(posedge core_clk)
        disable iff (rst || soft_rst)
        fetch.valid |-> $past(state_q) == ST_FETCH)
        else $error("fetch issued outside the fetch step");
    chk_reset_quiet: assert property (@(posedge core_clk)
        (rst || soft_rst) |=> !tx_active && !fetch.valid && rdata == 32'h0000_0000)
        else $error("outputs not quiet after reset");
endmodule

// *** testbench/desc_mem.sv ***
// Host memory model holding the link field of each descriptor.
// Assumes the fetch port of the pointer block on the same clock.
`timescale 1ns/10ps
module desc_mem (
    input  wire logic                 core_clk,
    input  wire transmit_descriptor_pointer_pkg::fetch_req_t fetch,
    input  wire logic [3:0]           delay,
    output      transmit_descriptor_pointer_pkg::fetch_rsp_t fetch_rsp
);
    import transmit_descriptor_pointer_pkg::*;
    logic [31:0] link_tbl [0:3];
    logic [31:0] addr_q;
    int          wait_q = -1;
    initial fetch_rsp = '0;
    // One answer per fetch after a set delay; the link line toggles when idle
    always @(posedge core_clk) begin
        fetch_rsp.valid <= 1'b0;
        fetch_rsp.link  <= ~fetch_rsp.link;
        if (fetch.valid) begin
            addr_q <= fetch.addr;
            wait_q <= delay;
        end else if (wait_q == 0) begin
            fetch_rsp <= '{valid: 1'b1, link: link_tbl[addr_q[5:4]]};
            wait_q    <= -1;
        end else if (wait_q > 0) begin
            wait_q <= wait_q - 1;
        end
    end
endmodule

// *** testbench/tb.sv ***
// Bench for the transmit descriptor list pointer.
// Assumes desc_mem answers link fetches on the same clock.
`timescale 1ns/10ps
module tb;
    import transmit_descriptor_pointer_pkg::*;
    logic        core_clk = 0, rst = 1, soft_rst = 0, desc_done = 0, tx_active;
    logic [3:0]  delay    = 0;
    logic [31:0] rdata, cur_desc;
    reg_req_t    req      = '0;
    fetch_req_t  fetch;
    fetch_rsp_t  fetch_rsp;
    int          failures = 0, comparisons = 0;
    always #10 core_clk = ~core_clk;
    tx_descriptor_list_pointer i_tx_descriptor_list_pointer (.core_clk(core_clk), .rst(rst),
        .soft_rst(soft_rst), .req(req), .rdata(rdata), .desc_done(desc_done), .fetch(fetch),
        .fetch_rsp(fetch_rsp), .tx_active(tx_active), .cur_desc(cur_desc));
    desc_mem i_desc_mem (.core_clk(core_clk), .fetch(fetch), .delay(delay),
        .fetch_rsp(fetch_rsp));
    // Compare and count
    task automatic check(input string name, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk) req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk) req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk) req <= '0;
        #1 check("rdata", rdata, exp);
    endtask
    // Optional done pulse, then one link fetch and its effect on the pointer
    task automatic step(input logic [31:0] at, nxt, input logic kick);
        if (kick) begin
            @(posedge core_clk) desc_done <= 1'b1;
            @(posedge core_clk) desc_done <= 1'b0;
        end
        for (int n = 0; n < 40 && fetch.valid !== 1'b1; n++) @(posedge core_clk) #1;
        check("fetch_valid", {31'h0, fetch.valid}, 32'h1);
        check("fetch_addr", fetch.addr, at);
        for (int n = 0; n < 40 && fetch_rsp.valid !== 1'b1; n++) @(posedge core_clk) #1;
        check("link_answer", {31'h0, fetch_rsp.valid}, 32'h1);
        repeat (2) @(posedge core_clk) #1;
        check("cur_desc", cur_desc, nxt);
        check("tx_active", {31'h0, tx_active}, {31'h0, nxt != at});
    endtask
    task automatic t_regs;
        rd(TRANSMIT_DESCRIPTOR_POINTER_OFFSET, TRANSMIT_DESCRIPTOR_POINTER_RESET);
        rd(8'h0C, 32'h0);
        wr(TRANSMIT_DESCRIPTOR_POINTER_OFFSET, 32'h0000_0013);
        rd(TRANSMIT_DESCRIPTOR_POINTER_OFFSET, 32'h0000_0010);
        $display("test regs done");
    endtask
    task automatic t_walk;
        i_desc_mem.link_tbl[1] = 32'h0000_0020;
        i_desc_mem.link_tbl[2] = 32'h0000_0030;
        i_desc_mem.link_tbl[3] = NULL_LINK;
        wr(CMD_OFFSET, 32'h0000_0001);
        step(32'h10, 32'h20, 1'b0);
        wr(TRANSMIT_DESCRIPTOR_POINTER_OFFSET, 32'h0000_0100);
        rd(TRANSMIT_DESCRIPTOR_POINTER_OFFSET, 32'h0000_0020);
        rd(STATUS_OFFSET, 32'h0000_0001);
        step(32'h20, 32'h30, 1'b1);
        step(32'h30, 32'h30, 1'b1);
        rd(STATUS_OFFSET, 32'h0000_0002);
        wr(CMD_OFFSET, 32'h0000_0000);
        rd(STATUS_OFFSET, 32'h0000_0002);
        $display("test walk done");
    endtask
    task automatic t_append;
        @(posedge core_clk) delay <= 4'h5;
        i_desc_mem.link_tbl[3] = 32'h0000_0040;
        i_desc_mem.link_tbl[0] = NULL_LINK;
        wr(CMD_OFFSET, 32'h0000_0001);
        step(32'h30, 32'h40, 1'b0);
        step(32'h40, 32'h40, 1'b1);
        @(posedge core_clk) soft_rst <= 1'b1;
        @(posedge core_clk) soft_rst <= 1'b0;
        rd(TRANSMIT_DESCRIPTOR_POINTER_OFFSET, TRANSMIT_DESCRIPTOR_POINTER_RESET);
        rd(STATUS_OFFSET, 32'h0);
        $display("test append done");
    endtask
    task automatic give_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        t_regs;
        t_walk;
        t_append;
        give_verdict;
    end
    // Watchdog well beyond the under a hundred cycles the tests need
    initial begin
        #100000;
        failures++;
        give_verdict;
    end
endmodule
